/* hw/fpcv_divider.sv */
`timescale 1ns/10ps
module fpcv_divider
   import fpcv_pkg::*;
#(
   parameter int QBITS = FPCV_DIV_QBITS
)
(
   input  wire logic              clk,
   input  wire logic              reset_n,
   input  wire logic              start,
   input  wire logic [52:0]       dividend,
   input  wire logic [52:0]       divisor,
   output logic                   busy,
   output logic                   done,
   output logic [QBITS-1:0]       quotient,
   output logic                   sticky
);
   logic [54:0] rem;
   logic [52:0] dsr;
   logic [6:0]  count;

   // Restoring division, one quotient bit a cycle; slow but small.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rem <= '0;
         dsr <= '0;
         count <= '0;
         busy <= 1'b0;
         done <= 1'b0;
         quotient <= '0;
      end else if (start) begin
         rem <= {2'h0, dividend};
         dsr <= divisor;
         count <= 7'(QBITS);
         busy <= 1'b1;
         done <= 1'b0;
         quotient <= '0;
      end else if (busy) begin
         if (rem >= {2'h0, dsr}) begin
            quotient <= {quotient[QBITS-2:0], 1'b1};
            rem <= (rem - {2'h0, dsr}) << 1;
         end else begin
            quotient <= {quotient[QBITS-2:0], 1'b0};
            rem <= rem << 1;
         end
         count <= count - 7'h1;
         busy <= (count != 7'h1);
         done <= (count == 7'h1);
      end else begin
         done <= 1'b0;
      end
   end

   // Any remainder left means the exact quotient has more bits.
   assign sticky = (rem != 55'h0);
endmodule

/* hw/fpcv_exec.sv */
`timescale 1ns/10ps
module fpcv_exec
   import fpcv_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        issue_valid,
   input  wire logic [31:0] instr,
   input  wire logic [63:0] src_value,
   input  wire logic [63:0] src2_value,
   input  wire logic [31:0] status_word,
   input  wire logic        cop_usable,
   input  wire logic        mode_64bit,
   input  wire logic        kernel_mode,
   input  wire logic [1:0]  round_mode,
   input  wire logic [4:0]  trap_enable,
   output logic             issue_ready,
   output logic             done,
   output logic             wr_en,
   output logic [4:0]       wr_index,
   output logic [63:0]      wr_data,
   output logic             wr_wide,
   output logic             wr_pair,
   output fpcv_flags_t      cause,
   output logic             fp_exception,
   output logic             reserved_instr,
   output logic             cop_unusable
);
   typedef enum logic {FPCV_IDLE, FPCV_DIVIDE} fpcv_state_t;

   fpcv_state_t        state;
   logic [4:0]         fmt;
   logic [4:0]         dest_field;
   logic               major_ok;
   logic               is_w;
   logic               is_l;
   logic               is_s;
   logic               is_div;
   logic               take;
   logic               fmt_float;
   logic               src_dbl;
   logic               pair_mode;
   fpcv_unp_t          ua;
   fpcv_unp_t          ub;
   logic [63:0]        ti_val;
   fpcv_flags_t        ti_flags;
   logic [63:0]        cs_val;
   fpcv_flags_t        cs_flags;
   logic [63:0]        dv_val;
   fpcv_flags_t        dv_flags;
   logic               dv_special;
   logic               div_start;
   logic               div_done;
   logic [56:0]        quot;
   logic               quot_sticky;
   logic               div_sign;
   logic signed [12:0] div_exp;
   logic               div_dbl;
   logic [1:0]         div_rm;
   logic [4:0]         div_dest;
   logic               div_pair;
   fpcv_rnd_t          qr;
   logic               fin_go;
   logic [63:0]        fin_val;
   fpcv_flags_t        fin_flags;
   logic [4:0]         fin_dest;
   logic               fin_wide;
   logic               fin_pair;
   logic               fin_unusable;
   logic               fin_reserved;
   logic               fin_trap;

   // Leading zero count of a nonzero 64-bit magnitude.
   function automatic logic [5:0] fpcv_lzc(input logic [63:0] v);
      logic [5:0] n;
      logic       seen;
      n = 6'h0;
      seen = 1'b0;
      for (int i = 63; i >= 0; i--) begin
         if (v[i]) seen = 1'b1;
         if (!seen) n = n + 6'h1;
      end
      return n;
   endfunction

   // Special values in the target format.
   function automatic logic [63:0] fpcv_inf(input logic s, input logic dbl);
      return dbl ? {s, 63'h7ff0000000000000} : {32'h0, s, 31'h7f800000};
   endfunction

   function automatic logic [63:0] fpcv_zero(input logic s, input logic dbl);
      return dbl ? {s, 63'h0} : {32'h0, s, 31'h0};
   endfunction

   // Instruction fields and decode.
   assign fmt = instr[25:21];
   assign dest_field = instr[10:6];
   assign major_ok = (instr[31:26] == FPCV_MAJOR);
   assign is_w = major_ok && (instr[20:16] == 5'h0) && (instr[5:0] == FPCV_FN_CONVERT_TO_WORD);
   assign is_l = major_ok && (instr[20:16] == 5'h0) && (instr[5:0] == FPCV_FN_CONVERT_TO_LONG);
   assign is_s = major_ok && (instr[20:16] == 5'h0) && (instr[5:0] == FPCV_FN_CONVERT_TO_SINGLE);
   assign is_div = major_ok && (instr[5:0] == FPCV_FN_DIV);
   assign issue_ready = (state == FPCV_IDLE);
   assign take = issue_valid && issue_ready && (is_w || is_l || is_s || is_div);
   assign fmt_float = (fmt == FPCV_FMT_S) || (fmt == FPCV_FMT_D);
   assign src_dbl = (fmt == FPCV_FMT_D);
   assign pair_mode = status_word[FPCV_PAIR_BIT];
   assign ua = fpcv_unpack(src_value, src_dbl);
   assign ub = fpcv_unpack(src2_value, src_dbl);

   // Float to fixed for both word and long.
   fpcv_to_int u_to_int (
      .is_long (is_l),
      .src     (ua),
      .rm      (round_mode),
      .result  (ti_val),
      .flags   (ti_flags)
   );

   // Convert to single from double, word or long.
   always_comb begin
      logic [63:0] ival;
      logic [63:0] mag;
      logic [5:0]  lz;
      fpcv_rnd_t   r;
      ival = '0;
      mag = '0;
      lz = '0;
      r = '0;
      cs_val = '0;
      cs_flags = '0;
      if (fmt == FPCV_FMT_D) begin
         if (ua.nan) begin
            cs_flags.invalid = 1'b1;
            cs_val = FPCV_QNAN_S;
         end else if (ua.inf) begin
            cs_val = fpcv_inf(ua.sign, 1'b0);
         end else if (ua.zero) begin
            cs_val = fpcv_zero(ua.sign, 1'b0);
         end else if (ua.denorm) begin
            cs_flags.unimpl = 1'b1;
         end else begin
            r = fpcv_round(ua.sign, ua.exp, {ua.mant, 11'h0}, round_mode, 1'b0);
         end
      end else if (fmt == FPCV_FMT_W || fmt == FPCV_FMT_L) begin
         ival = (fmt == FPCV_FMT_W) ? {{32{src_value[31]}}, src_value[31:0]} : src_value;
         mag = ival[63] ? (~ival + 64'h1) : ival;
         if (mag != 64'h0) begin
            lz = fpcv_lzc(mag);
            r = fpcv_round(ival[63], 13'sd63 - {7'h0, lz}, mag << lz, round_mode, 1'b0);
         end
         cs_flags.unimpl = (fmt == FPCV_FMT_L) && (|src_value[62:55]);
      end else begin
         cs_flags.unimpl = 1'b1;
      end
      if (r.val != 64'h0 || r.ovf || r.unf) cs_val = r.val;
      cs_flags.overflow = r.ovf;
      cs_flags.underflow = r.unf;
      cs_flags.inexact = r.inx;
   end

   // Divide cases settled without the iterative divider.
   always_comb begin
      dv_special = 1'b1;
      dv_val = '0;
      dv_flags = '0;
      if (!fmt_float) begin
         dv_flags.unimpl = 1'b1;
      end else if (ua.denorm || ub.denorm) begin
         dv_flags.unimpl = 1'b1;
      end else if (ua.nan || ub.nan || (ua.zero && ub.zero) || (ua.inf && ub.inf)) begin
         dv_flags.invalid = 1'b1;
         dv_val = src_dbl ? FPCV_QNAN_D : FPCV_QNAN_S;
      end else if (ua.inf || ub.zero) begin
         dv_flags.divzero = ub.zero && !ua.inf;
         dv_val = fpcv_inf(ua.sign ^ ub.sign, src_dbl);
      end else if (ua.zero || ub.inf) begin
         dv_val = fpcv_zero(ua.sign ^ ub.sign, src_dbl);
      end else begin
         dv_special = 1'b0;
      end
   end

   assign div_start = take && is_div && cop_usable && !dv_special;

   // Mantissa quotient, carried over many cycles.
   fpcv_divider u_divider (
      .clk      (clk),
      .reset_n  (reset_n),
      .start    (div_start),
      .dividend (ua.mant),
      .divisor  (ub.mant),
      .busy     (),
      .done     (div_done),
      .quotient (quot),
      .sticky   (quot_sticky)
   );

   // Issue state; the pipeline is held off while a divide runs.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) state <= FPCV_IDLE;
      else if (div_start) state <= FPCV_DIVIDE;
      else if (div_done) state <= FPCV_IDLE;
   end

   // Divide context captured at issue, mode included.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         div_sign <= 1'b0;
         div_exp <= '0;
         div_dbl <= 1'b0;
         div_rm <= '0;
         div_dest <= '0;
         div_pair <= 1'b0;
      end else if (div_start) begin
         div_sign <= ua.sign ^ ub.sign;
         div_exp <= ua.exp - ub.exp;
         div_dbl <= src_dbl;
         div_rm <= round_mode;
         div_dest <= dest_field;
         div_pair <= src_dbl && !pair_mode;
      end
   end

   // Normalise the quotient by one place when quot[56] is clear, and round it.
   always_comb begin
      if (quot[56]) qr = fpcv_round(div_sign, div_exp, {quot, 6'h0, quot_sticky}, div_rm,
                                    div_dbl);
      else qr = fpcv_round(div_sign, div_exp - 13'sd1, {quot[55:0], 7'h0, quot_sticky},
                           div_rm, div_dbl);
   end

   // Selects what finishes this cycle: a divide or a one-cycle operation.
   always_comb begin
      fin_go = 1'b0;
      fin_val = '0;
      fin_flags = '0;
      fin_dest = dest_field;
      fin_wide = 1'b0;
      fin_unusable = 1'b0;
      fin_reserved = 1'b0;
      if (div_done) begin
         fin_go = 1'b1;
         fin_val = qr.val;
         fin_flags.overflow = qr.ovf;
         fin_flags.underflow = qr.unf;
         fin_flags.inexact = qr.inx;
         fin_dest = div_dest;
         fin_wide = div_dbl;
      end else if (take && !div_start) begin
         fin_go = 1'b1;
         if (!cop_usable) begin
            fin_unusable = 1'b1;
         end else if (is_l && !mode_64bit && !kernel_mode) begin
            fin_reserved = 1'b1;
         end else if (is_w || is_l) begin
            fin_val = ti_val;
            fin_flags = ti_flags;
            fin_flags.unimpl = ti_flags.unimpl || !fmt_float;
            fin_wide = is_l;
         end else if (is_s) begin
            fin_val = cs_val;
            fin_flags = cs_flags;
         end else begin
            fin_val = dv_val;
            fin_flags = dv_flags;
            fin_wide = src_dbl;
         end
      end
   end

   // Unimplemented always traps; the others only when enabled.
   assign fin_trap = fin_flags.unimpl || (|(fin_flags[4:0] & trap_enable));
   assign fin_pair = div_done ? div_pair : (fin_wide && !pair_mode);

   // Result and cause outputs, held until the next completion; done, write enable and exception outputs last one cycle.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         done <= 1'b0;
         wr_en <= 1'b0;
         wr_index <= '0;
         wr_data <= '0;
         wr_wide <= 1'b0;
         wr_pair <= 1'b0;
         cause <= '0;
         fp_exception <= 1'b0;
         reserved_instr <= 1'b0;
         cop_unusable <= 1'b0;
      end else begin
         done <= fin_go;
         wr_en <= fin_go && !fin_trap && !fin_unusable && !fin_reserved;
         fp_exception <= fin_go && fin_trap && !fin_unusable && !fin_reserved;
         reserved_instr <= fin_reserved;
         cop_unusable <= fin_unusable;
         if (fin_go) begin
            wr_index <= fin_dest;
            wr_data <= fin_val;
            wr_wide <= fin_wide;
            wr_pair <= fin_pair;
            cause <= fin_flags;
         end
      end
   end

   // Checks on the finished instruction.
   a_div_holds_issue: assert property (@(posedge clk) disable iff (!reset_n)
      div_start |=> !issue_ready [*8]) else $error("issue accepted during divide");
   a_div_latency: assert property (@(posedge clk) disable iff (!reset_n)
      div_start |-> ##59 done) else $error("divide latency wrong");
   a_cvt_one_cycle: assert property (@(posedge clk) disable iff (!reset_n)
      take && !div_start |=> done) else $error("conversion not done next cycle");
   a_reserved_long: assert property (@(posedge clk) disable iff (!reset_n)
      take && is_l && cop_usable && !mode_64bit && !kernel_mode
      |=> reserved_instr && !wr_en) else $error("long in user mode not refused");
   a_unusable_only: assert property (@(posedge clk) disable iff (!reset_n)
      take && !cop_usable |=> cop_unusable && !wr_en && !fp_exception)
      else $error("unusable coprocessor not reported");
   a_trap_no_write: assert property (@(posedge clk) disable iff (!reset_n)
      done && cause.unimpl && !cop_unusable && !reserved_instr |-> fp_exception && !wr_en)
      else $error("unimplemented did not trap");
   a_long_src_bits: assert property (@(posedge clk) disable iff (!reset_n)
      take && is_s && cop_usable && fmt == FPCV_FMT_L && (|src_value[62:55])
      |=> cause.unimpl) else $error("long source bits not unimplemented");
   a_bad_format: assert property (@(posedge clk) disable iff (!reset_n)
      take && is_w && cop_usable && !fmt_float |=> cause.unimpl)
      else $error("fixed source accepted by word convert");
   a_pair_bit: assert property (@(posedge clk) disable iff (!reset_n)
      take && !div_start |=> wr_pair == (wr_wide && !$past(status_word[FPCV_PAIR_BIT])))
      else $error("pair mode not taken from status");
   a_word_upper: assert property (@(posedge clk) disable iff (!reset_n)
      take && is_w && cop_usable |=> wr_data[63:32] == 32'h0)
      else $error("word result upper half not zero");

   c_divide_done: cover property (@(posedge clk) disable iff (!reset_n)
      div_start ##59 (done && wr_en));
   c_single_write: cover property (@(posedge clk) disable iff (!reset_n)
      take && is_s ##1 wr_en);
   c_fp_trap: cover property (@(posedge clk) disable iff (!reset_n) fp_exception);
   c_reserved: cover property (@(posedge clk) disable iff (!reset_n) reserved_instr);
endmodule

/* hw/fpcv_to_int.sv */
`timescale 1ns/10ps
module fpcv_to_int
   import fpcv_pkg::*;
(
   input  wire logic        is_long,
   input  wire fpcv_unp_t   src,
   input  wire logic [1:0]  rm,
   output logic [63:0]      result,
   output fpcv_flags_t      flags
);
   logic [127:0]       shifted;
   logic [64:0]        mag;
   logic [64:0]        lim;
   logic [63:0]        sgn;
   logic               st;
   logic               inc;
   logic               over;
   logic signed [12:0] sh;

   // Fixed point sits at bit 64, so the shift is the exponent plus one.
   always_comb begin
      sh = src.exp + 13'sd1;
      shifted = '0;
      st = 1'b0;
      if (sh >= 13'sd0 && sh <= 13'sd63) shifted = {64'h0, src.mant, 11'h0} << sh[5:0];
      else if (sh < 13'sd0) st = ~src.zero;
      st = st | (|shifted[62:0]);
      case (rm)
         FPCV_RM_NEAR:  inc = shifted[63] & (st | shifted[64]);
         FPCV_RM_PLUS:  inc = ~src.sign & (shifted[63] | st);
         FPCV_RM_MINUS: inc = src.sign & (shifted[63] | st);
         default:       inc = 1'b0;
      endcase
      mag = {1'b0, shifted[127:64]} + {64'h0, inc};
      lim = (is_long ? {1'b0, FPCV_LONG_MAX} : {1'b0, FPCV_WORD_MAX}) + {64'h0, src.sign};
      over = (sh > 13'sd63) | (mag > lim);
      sgn = src.sign ? (~mag[63:0] + 64'h1) : mag[63:0];
      flags = '0;
      flags.invalid = src.inf | src.nan | over;
      flags.unimpl = src.inf | src.nan | over | src.denorm | (|mag[64:53]);
      flags.inexact = ~flags.invalid & (shifted[63] | st);
      // An untrapped invalid result is the largest positive value.
      if (flags.invalid) result = is_long ? FPCV_LONG_MAX : FPCV_WORD_MAX;
      else result = is_long ? sgn : {32'h0, sgn[31:0]};
   end
endmodule

/* pkg/fpcv_pkg.sv */
// Notes on behaviour
// - Convert-to-word: major 010001, bits 20..16 zero, function 100100; fields fixed.
// - Convert-to-long: major opcode, bits 20..16 zero, function 100101.
// - Convert-to-long turns the source into a 64-bit integer for the destination.
// - Long, word and divide accept only single or double source formats.
// - Long: infinity, NaN or out of range is invalid; untrapped writes 2^63-1.
// - Long in 32-bit user or supervisor mode raises reserved instruction.
// - Convert-to-single rounds by the current rounding mode and writes the destination.
// - Convert-to-single accepts double, 32-bit fixed or 64-bit fixed sources only.
// - Word: infinity, NaN or out of range is invalid; untrapped writes 2^31-1.
// - Divide, function 000011, divides exactly, rounds by mode, writes the destination.
// - Float-to-fixed result with any of bits 53..62 set is unimplemented.
// - Long fixed source with any of bits 55..62 set is unimplemented.
// - Integer conversion overflow, infinite or NaN source is unimplemented.
// - Single and divide may underflow; only divide flags division by zero.
// - Unusable coprocessor raises unusable; enabled conditions raise the FP trap.
// - Register pair mode is status bit 26.
package fpcv_pkg;
   localparam logic [5:0]  FPCV_MAJOR    = 6'h11;
   localparam logic [5:0]  FPCV_FN_CONVERT_TO_WORD = 6'h24;
   localparam logic [5:0]  FPCV_FN_CONVERT_TO_LONG = 6'h25;
   localparam logic [5:0]  FPCV_FN_CONVERT_TO_SINGLE = 6'h20;
   localparam logic [5:0]  FPCV_FN_DIV   = 6'h03;
   localparam logic [4:0]  FPCV_FMT_S    = 5'h10;
   localparam logic [4:0]  FPCV_FMT_D    = 5'h11;
   localparam logic [4:0]  FPCV_FMT_W    = 5'h14;
   localparam logic [4:0]  FPCV_FMT_L    = 5'h15;
   localparam int          FPCV_PAIR_BIT = 26;
   localparam logic [1:0]  FPCV_RM_NEAR  = 2'h0;
   localparam logic [1:0]  FPCV_RM_PLUS  = 2'h2;
   localparam logic [1:0]  FPCV_RM_MINUS = 2'h3;
   localparam int          FPCV_DIV_QBITS = 57;
   localparam logic [63:0] FPCV_LONG_MAX = 64'h7fffffffffffffff;
   localparam logic [63:0] FPCV_WORD_MAX = 64'h000000007fffffff;
   localparam logic [63:0] FPCV_QNAN_S   = 64'h000000007fbfffff;
   localparam logic [63:0] FPCV_QNAN_D   = 64'h7ff7ffffffffffff;

   // Cause bits; the low five line up with the trap enables.
   typedef struct packed {
      logic unimpl;
      logic invalid;
      logic divzero;
      logic overflow;
      logic underflow;
      logic inexact;
   } fpcv_flags_t;

   typedef struct packed {
      logic               sign;
      logic signed [12:0] exp;
      logic [52:0]        mant;
      logic               zero;
      logic               inf;
      logic               nan;
      logic               denorm;
   } fpcv_unp_t;

   typedef struct packed {
      logic [63:0] val;
      logic        ovf;
      logic        unf;
      logic        inx;
   } fpcv_rnd_t;

   // Splits a register value into sign, unbiased exponent and significand.
   function automatic fpcv_unp_t fpcv_unpack(input logic [63:0] v, input logic dbl);
      fpcv_unp_t   u;
      logic [10:0] e;
      logic [51:0] f;
      logic        emax;
      e = dbl ? v[62:52] : {3'h0, v[30:23]};
      f = dbl ? v[51:0] : {v[22:0], 29'h0};
      emax = dbl ? (&v[62:52]) : (&v[30:23]);
      u.sign = dbl ? v[63] : v[31];
      u.exp = {2'h0, e} - (dbl ? 13'd1023 : 13'd127);
      u.mant = {(e != 11'h0), f};
      u.zero = (e == 11'h0) && (f == 52'h0);
      u.denorm = (e == 11'h0) && (f != 52'h0);
      u.inf = emax && (f == 52'h0);
      u.nan = emax && (f != 52'h0);
      return u;
   endfunction

   // Rounds a significand with its leading one at bit 63 and packs it.
   function automatic fpcv_rnd_t fpcv_round(input logic s, input logic signed [12:0] ex,
                                            input logic [63:0] sig, input logic [1:0] rm,
                                            input logic dbl);
      fpcv_rnd_t          r;
      logic [53:0]        m;
      logic               g;
      logic               st;
      logic               inc;
      logic               up;
      logic signed [12:0] be;
      r = '0;
      m = dbl ? {1'b0, sig[63:11]} : {30'h0, sig[63:40]};
      g = dbl ? sig[10] : sig[39];
      st = dbl ? (|sig[9:0]) : (|sig[38:0]);
      case (rm)
         FPCV_RM_NEAR:  inc = g & (st | m[0]);
         FPCV_RM_PLUS:  inc = ~s & (g | st);
         FPCV_RM_MINUS: inc = s & (g | st);
         default:       inc = 1'b0;
      endcase
      m = m + {53'h0, inc};
      be = ex + (dbl ? 13'sd1023 : 13'sd127);
      if (dbl ? m[53] : m[24]) begin
         be = be + 13'sd1;
         m = m >> 1;
      end
      r.inx = g | st;
      up = (rm == FPCV_RM_NEAR) | ((rm == FPCV_RM_PLUS) & ~s) | ((rm == FPCV_RM_MINUS) & s);
      if (be >= (dbl ? 13'sd2047 : 13'sd255)) begin
         r.ovf = 1'b1;
         r.inx = 1'b1;
         if (dbl) r.val = {s, up ? 63'h7ff0000000000000 : 63'h7fefffffffffffff};
         else r.val = {32'h0, s, up ? 31'h7f800000 : 31'h7f7fffff};
      end else if (be <= 13'sd0) begin
         // Tiny results flush to a signed zero rather than denormalise.
         r.unf = 1'b1;
         r.inx = 1'b1;
         r.val = dbl ? {s, 63'h0} : {32'h0, s, 31'h0};
      end else if (dbl) begin
         r.val = {s, be[10:0], m[51:0]};
      end else begin
         r.val = {32'h0, s, be[7:0], m[22:0]};
      end
      return r;
   endfunction
endpackage

/* testbench/fpcv_issue_model.sv */
`timescale 1ns/10ps
// Pipeline side: offers one instruction per request and holds it until taken.
module fpcv_issue_model
   import fpcv_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        go,
   input  wire logic [31:0] word,
   input  wire logic        pair_mode,
   input  wire logic        issue_ready,
   output logic             issue_valid,
   output logic [31:0]      instr
);
   // Offer is held until sampled with ready; afterwards the word is inverted
   // so that nothing can lean on a stale copy of the last instruction.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         issue_valid <= 1'b0;
         instr <= 32'h0;
      end else if (issue_valid && issue_ready) begin
         issue_valid <= 1'b0;
         instr <= ~instr;
      end else if (go && !issue_valid) begin
         issue_valid <= 1'b1;
         instr <= pair_mode ? word : {word[31:7], 1'b0, word[5:0]};
      end
   end
endmodule

/* testbench/test_fpcv_exec.sv */
`timescale 1ns/10ps
module test_fpcv_exec
   import fpcv_pkg::*;
;
   logic clk = 0, reset_n = 0, go = 0, pair = 0, usable = 1, m64 = 1, kern = 1;
   logic [1:0] rm = 2'h0;
   logic [4:0] te = 5'h0;
   logic [31:0] word = 32'h0, instr;
   logic [63:0] src_value = 64'h0, src2_value = 64'h0, wr_data;
   logic issue_valid, issue_ready, done, wr_en, fp_exception, reserved_instr, cop_unusable;
   logic wr_wide, wr_pair;
   logic [4:0] wr_index;
   fpcv_flags_t cause;
   int err_total = 0, checked = 0, seed = 56, tn = 0, v;
   localparam logic [14:0] F = 15'h7fff, M = 15'h7fe0, R = 15'h7fc0;
   always #10 clk = ~clk;
   fpcv_issue_model model (.clk, .reset_n, .go, .word, .pair_mode(pair), .issue_ready,
                           .issue_valid, .instr);
   fpcv_exec dut (.clk, .reset_n, .issue_valid, .instr, .src_value, .src2_value,
                  .status_word({5'h0, pair, 26'h0}), .cop_usable(usable), .mode_64bit(m64),
                  .kernel_mode(kern), .round_mode(rm), .trap_enable(te), .issue_ready, .done,
                  .wr_en, .wr_index, .wr_data, .wr_wide, .wr_pair, .cause, .fp_exception,
                  .reserved_instr, .cop_unusable);
   // Closing report, also reached when a wait runs out.
   task automatic print_verdict();
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Fields: source register 2, destination 6; the format and function vary.
   function automatic logic [31:0] ins(input logic [4:0] f, input logic [5:0] fn);
      return {FPCV_MAJOR, f, 5'h0, 5'd2, 5'd6, fn};
   endfunction
   // Issues one instruction, waits for done, compares pulses, cause and latency.
   task automatic tc(input logic [31:0] w, input logic [63:0] a, input logic [63:0] b,
                     input logic [63:0] x, input logic [14:0] ef, input logic [14:0] m,
                     input int en);
      int n;
      logic wd;
      src_value = a;
      src2_value = b;
      word = w;
      go = 1;
      @(posedge clk);
      #1 go = 0;
      // The edge that samples go counts as the first, so the offer cycle is included.
      for (n = 1; n < 80 && done !== 1'b1; n++) begin
         @(posedge clk);
         #1;
      end
      if (done !== 1'b1) begin
         err_total++;
         print_verdict();
      end
      chk({49'h0, wr_index, wr_en, fp_exception, reserved_instr, cop_unusable, cause} & m, ef & m);
      if (ef[9]) chk(wr_data, x);
      // Long results and double divides are 64 bits wide and paired unless pair mode is on.
      wd = (w[5:0] == FPCV_FN_CONVERT_TO_LONG) || (w[5:0] == FPCV_FN_DIV && w[25:21] == FPCV_FMT_D);
      if (ef[9]) chk({wr_wide, wr_pair}, {wd, wd & ~pair});
      chk(n, en);
      tn++;
      $display("test %0d done", tn);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      #1 reset_n = 1;
      tc(ins(FPCV_FMT_S, FPCV_FN_CONVERT_TO_WORD), 64'h3f800000, 0, 64'h1, 15'h1a00, F, 2);
      tc(ins(FPCV_FMT_D, FPCV_FN_CONVERT_TO_LONG), 64'h4000000000000000, 0, 64'h2, 15'h1a00, F, 2);
      m64 = 0;
      kern = 0;
      tc(ins(FPCV_FMT_D, FPCV_FN_CONVERT_TO_LONG), 64'h4000000000000000, 0, 0, 15'h1880, R, 2);
      kern = 1;
      pair = 1;
      tc(ins(FPCV_FMT_D, FPCV_FN_CONVERT_TO_LONG), 64'h4000000000000000, 0, 64'h2, 15'h1a00, F, 2);
      pair = 0;
      m64 = 1;
      usable = 0;
      tc(ins(FPCV_FMT_S, FPCV_FN_CONVERT_TO_WORD), 64'h3f800000, 0, 0, 15'h1840, R, 2);
      usable = 1;
      tc(ins(FPCV_FMT_S, FPCV_FN_CONVERT_TO_WORD), 64'h7fc00000, 0, 0, 15'h1920, M, 2);
      tc(ins(FPCV_FMT_D, FPCV_FN_CONVERT_TO_LONG), 64'h43b0000000000000, 0, 0, 15'h1920, M, 2);
      tc(ins(FPCV_FMT_W, FPCV_FN_CONVERT_TO_WORD), 64'h1, 0, 0, 15'h1920, M, 2);
      tc(ins(FPCV_FMT_S, FPCV_FN_CONVERT_TO_SINGLE), 64'h3f800000, 0, 0, 15'h1920, M, 2);
      tc(ins(FPCV_FMT_W, FPCV_FN_CONVERT_TO_SINGLE), 64'h1, 0, 64'h3f800000, 15'h1a00, F, 2);
      tc(ins(FPCV_FMT_L, FPCV_FN_CONVERT_TO_SINGLE), 64'h0100000000000000, 0, 0, 15'h1920, M, 2);
      // Ties to even keeps 2^24 while rounding upward takes the next value.
      tc(ins(FPCV_FMT_L, FPCV_FN_CONVERT_TO_SINGLE), 64'h1000001, 0, 64'h4b800000, 15'h1a01, F, 2);
      rm = FPCV_RM_PLUS;
      tc(ins(FPCV_FMT_L, FPCV_FN_CONVERT_TO_SINGLE), 64'h1000001, 0, 64'h4b800001, 15'h1a01, F, 2);
      // Rounding downward takes -1.5 to -2.
      rm = FPCV_RM_MINUS;
      tc(ins(FPCV_FMT_S, FPCV_FN_CONVERT_TO_WORD), 64'hbfc00000, 0, 64'hfffffffe, 15'h1a01, F, 2);
      rm = FPCV_RM_NEAR;
      tc(ins(FPCV_FMT_D, FPCV_FN_CONVERT_TO_SINGLE), 64'h3ff8000000000000, 0, 64'h3fc00000, 15'h1a00,
         F, 2);
      tc(ins(FPCV_FMT_D, FPCV_FN_DIV) | 32'h40000, 64'h3ff0000000000000, 64'h4000000000000000,
         64'h3fe0000000000000, 15'h1a00, F, 60);
      te = 5'h08;
      tc(ins(FPCV_FMT_D, FPCV_FN_DIV) | 32'h40000, 64'h3ff0000000000000, 0, 0, 15'h1908,
         15'h7fc8, 2);
      te = 5'h0;
      // Random integers convert exactly, so the long result is the integer itself.
      repeat (6) begin
         v = $random(seed);
         tc(ins(FPCV_FMT_D, FPCV_FN_CONVERT_TO_LONG), $realtobits($itor(v)), 0, {{32{v[31]}}, v},
            15'h1a00, F, 2);
      end
      print_verdict();
   end
endmodule
